// ===== include/lpm_pkg.sv
// Constants for the indicator light and shared pin function selector
package lpm_pkg;

    // Register byte offsets
    localparam logic [11:0] LPM_WAKE_CTRL_STATUS_OFS = 12'h000;
    localparam logic [11:0] LPM_STRAP_STATUS_OFS     = 12'h004;
    localparam logic [11:0] LPM_IRQ_STATUS_OFS       = 12'h008;
    localparam logic [11:0] LPM_IRQ_MASK_OFS         = 12'h00c;

    // Fields of the wake control and status register
    localparam int LPM_LIGHT_A_SEL_LSB = 0;
    localparam int LPM_LIGHT_B_SEL_LSB = 2;
    localparam int LPM_IRQ_ROUTE_LSB   = 4;
    localparam int LPM_WAKE_ROUTE_LSB  = 6;
    localparam int LPM_CTRL_WIDTH      = 8;

    // Strap status fields
    localparam int LPM_STRAP_MODE_BIT   = 0;
    localparam int LPM_STRAP_CORE_REGULATOR_DISABLE_STRAP_BIT = 1;

    // Interrupt status and mask fields
    localparam int LPM_EV_IRQ_BIT   = 0;
    localparam int LPM_EV_WAKE_BIT  = 1;
    localparam int LPM_EV_LINK_BIT  = 2;
    localparam int LPM_EV_WIDTH     = 3;

    localparam logic [LPM_CTRL_WIDTH-1:0] LPM_CTRL_RESET = 8'h00;
    localparam logic [LPM_EV_WIDTH-1:0]   LPM_MASK_RESET = 3'h0;

    // Light function codes
    typedef enum logic [1:0] {
        LPM_FN_ACTIVITY = 2'b00,
        LPM_FN_SPEED    = 2'b01,
        LPM_FN_IRQ      = 2'b10,
        LPM_FN_WAKE     = 2'b11
    } lpm_light_fn_t;

    // Interrupt routing codes
    typedef enum logic [1:0] {
        LPM_IRQ_SHARED  = 2'b00,
        LPM_IRQ_LIGHT_A = 2'b01,
        LPM_IRQ_LIGHT_B = 2'b10,
        LPM_IRQ_NONE    = 2'b11
    } lpm_irq_route_t;

    // Wake routing codes
    typedef enum logic [1:0] {
        LPM_WAKE_NONE    = 2'b00,
        LPM_WAKE_LIGHT_A = 2'b01,
        LPM_WAKE_LIGHT_B = 2'b10,
        LPM_WAKE_RXD     = 2'b11
    } lpm_wake_route_t;

endpackage

// ===== logic/lpm_strap_latch.sv
// Strap capture stage: samples strap levels while capture_i is high; reset loads the pulled defaults
`timescale 1ns/10ps
module lpm_strap_latch
    import lpm_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Capture request and strap pins
    input  wire logic capture_i,
    input  wire logic mode_strap_i,
    input  wire logic core_regulator_disable_strap_strap_i,
    // Latched values
    output logic      mode_strap_o,
    output logic      core_regulator_disable_strap_strap_o
);

    // Reset value is the pulled default; capture overwrites it while requested
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_strap_o   <= 1'b1;
            core_regulator_disable_strap_strap_o <= 1'b0;
        end else if (capture_i) begin
            mode_strap_o   <= mode_strap_i;
            core_regulator_disable_strap_strap_o <= core_regulator_disable_strap_strap_i;
        end
    end

endmodule // lpm_strap_latch

// ===== logic/lpm_pin_select.sv
// Indicator light, interrupt and wake pin function selector with APB registers
//
// Behaviour
// - Each light pin shows activity, speed, interrupt or wake per its select field.
// - Interrupt output is active low; low means pending.
// - Interrupt defaults to shared pin; may be routed to either light pin.
// - Wake event output is active low; low means wake occurred.
// - Wake output routable to light A, light B or the receive-data-3 pin.
// - Mode strap high or floating at reset: shared pin is interrupt output.
// - Mode strap low at reset: shared pin is transmit-error/data-4 input.
// - Regulator strap high disables core regulator; low or floating leaves it on.
// - Straps latch at power-on and every system reset, held until next.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
module lpm_pin_select
    import lpm_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    // System reset pin, active low, synchronous
    input  wire logic        sys_rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Internal event sources, active high
    input  wire logic        link_activity_i,
    input  wire logic        link_speed_i,
    input  wire logic        irq_req_i,
    input  wire logic        wake_req_i,
    // Strap pins
    input  wire logic        shared_pin_mode_strap_i,
    input  wire logic        core_regulator_disable_strap_i,
    // Shared interrupt / transmit-error pin
    input  wire logic        shared_pin_i,
    output logic             shared_pin_o,
    output logic             shared_pin_oe_o,
    output logic             tx_err_d4_o,
    // Receive-data-3 pin wake function
    output logic             rxd_wake_o,
    output logic             rxd_wake_oe_o,
    // Light pins
    output logic             status_light_a_o,
    output logic             status_light_b_o,
    // Regulator control and interrupt
    output logic             core_regulator_en_o,
    output logic             bus_irq_o
);

    logic                      rst_sync1_reg;
    logic                      rst_sync2_reg;
    logic                      sys_rst_d_reg;
    logic [LPM_CTRL_WIDTH-1:0] ctrl_reg;
    logic [LPM_EV_WIDTH-1:0]   irq_status_reg;
    logic [LPM_EV_WIDTH-1:0]   irq_status_next;
    logic [LPM_EV_WIDTH-1:0]   irq_mask_reg;
    logic [LPM_EV_WIDTH-1:0]   ev_prev_reg;
    logic [LPM_EV_WIDTH-1:0]   ev_now;
    logic [31:0]               rdata_next;
    logic                      map_hit;
    logic                      strap_mode;
    logic                      strap_core_regulator_disable_strap;
    logic                      capture;
    logic                      irq_n;
    logic                      wake_n;
    lpm_light_fn_t             sel_a;
    lpm_light_fn_t             sel_b;
    lpm_irq_route_t            irq_route;
    lpm_wake_route_t           wake_route;

    // Reset release through two flip-flops
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    // System reset is a level already synchronous to the clock
    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            sys_rst_d_reg <= 1'b1;
        end else begin
            sys_rst_d_reg <= ~sys_rst_n_i;
        end
    end

    // Capture during the first cycle after power-on and while system reset holds
    assign capture = sys_rst_d_reg;

    lpm_strap_latch u_strap (
        .clock_i        (clock_i),
        .rst_n_i        (rst_sync2_reg),
        .capture_i      (capture),
        .mode_strap_i   (shared_pin_mode_strap_i),
        .core_regulator_disable_strap_strap_i (core_regulator_disable_strap_i),
        .mode_strap_o   (strap_mode),
        .core_regulator_disable_strap_strap_o (strap_core_regulator_disable_strap)
    );

    // Decode helpers
    function automatic logic sel_pin(input lpm_light_fn_t fn, input logic act,
                                     input logic spd, input logic in_n,
                                     input logic wk_n);
        unique case (fn)
            LPM_FN_ACTIVITY: sel_pin = act;
            LPM_FN_SPEED:    sel_pin = spd;
            LPM_FN_IRQ:      sel_pin = in_n;
            LPM_FN_WAKE:     sel_pin = wk_n;
        endcase
    endfunction

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        addr_is = (a == ofs);
    endfunction

    assign sel_a      = lpm_light_fn_t'(ctrl_reg[LPM_LIGHT_A_SEL_LSB +: 2]);
    assign sel_b      = lpm_light_fn_t'(ctrl_reg[LPM_LIGHT_B_SEL_LSB +: 2]);
    assign irq_route  = lpm_irq_route_t'(ctrl_reg[LPM_IRQ_ROUTE_LSB +: 2]);
    assign wake_route = lpm_wake_route_t'(ctrl_reg[LPM_WAKE_ROUTE_LSB +: 2]);

    assign irq_n  = ~irq_req_i;
    assign wake_n = ~wake_req_i;

    // Pin drivers, all registered
    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            status_light_a_o <= 1'b0;
            status_light_b_o <= 1'b0;
            shared_pin_o     <= 1'b1;
            shared_pin_oe_o  <= 1'b0;
            tx_err_d4_o      <= 1'b0;
            rxd_wake_o       <= 1'b1;
            rxd_wake_oe_o    <= 1'b0;
        end else begin
            status_light_a_o <= sel_pin(sel_a, link_activity_i, link_speed_i,
                                        irq_n, wake_n);
            status_light_b_o <= sel_pin(sel_b, link_activity_i, link_speed_i,
                                        irq_n, wake_n);
            // Interrupt on the shared pin only when routed there and strapped for it
            shared_pin_o    <= (irq_route == LPM_IRQ_SHARED) ? irq_n : 1'b1;
            shared_pin_oe_o <= strap_mode;
            // Pin acts as input when strapped low; output driver is released
            tx_err_d4_o     <= strap_mode ? 1'b0 : shared_pin_i;
            rxd_wake_o      <= wake_n;
            rxd_wake_oe_o   <= (wake_route == LPM_WAKE_RXD);
        end
    end

    // Light routing of interrupt and wake overrides the field select
    // Kept in the field encoding so a single select field steers each light
    // and routes act by rewriting the light fields on write

    // Regulator enable follows the latched strap; external rail needed when off
    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            core_regulator_en_o <= 1'b1;
        end else begin
            core_regulator_en_o <= ~strap_core_regulator_disable_strap;
        end
    end

    // Control register write
    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            ctrl_reg <= LPM_CTRL_RESET;
        end else if (psel_i && penable_i && pwrite_i
                     && addr_is(paddr_i, LPM_WAKE_CTRL_STATUS_OFS)) begin
            ctrl_reg <= pwdata_i[LPM_CTRL_WIDTH-1:0];
            // Routing the interrupt to a light forces that light's function
            if (pwdata_i[LPM_IRQ_ROUTE_LSB +: 2] == LPM_IRQ_LIGHT_A) begin
                ctrl_reg[LPM_LIGHT_A_SEL_LSB +: 2] <= LPM_FN_IRQ;
            end
            if (pwdata_i[LPM_IRQ_ROUTE_LSB +: 2] == LPM_IRQ_LIGHT_B) begin
                ctrl_reg[LPM_LIGHT_B_SEL_LSB +: 2] <= LPM_FN_IRQ;
            end
            if (pwdata_i[LPM_WAKE_ROUTE_LSB +: 2] == LPM_WAKE_LIGHT_A) begin
                ctrl_reg[LPM_LIGHT_A_SEL_LSB +: 2] <= LPM_FN_WAKE;
            end
            if (pwdata_i[LPM_WAKE_ROUTE_LSB +: 2] == LPM_WAKE_LIGHT_B) begin
                ctrl_reg[LPM_LIGHT_B_SEL_LSB +: 2] <= LPM_FN_WAKE;
            end
        end
    end

    // Mask register write
    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            irq_mask_reg <= LPM_MASK_RESET;
        end else if (psel_i && penable_i && pwrite_i
                     && addr_is(paddr_i, LPM_IRQ_MASK_OFS)) begin
            irq_mask_reg <= pwdata_i[LPM_EV_WIDTH-1:0];
        end
    end

    // Rising edges of interrupt, wake and link activity are the events
    assign ev_now = {link_activity_i, wake_req_i, irq_req_i};

    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            ev_prev_reg <= '0;
        end else begin
            ev_prev_reg <= ev_now;
        end
    end

    // Sticky status: a read clears only the bits it reported, so an event that lands
    // between the setup and access edges is not lost; a new event still wins
    always_comb begin
        irq_status_next = irq_status_reg;
        if (psel_i && penable_i && !pwrite_i
            && addr_is(paddr_i, LPM_IRQ_STATUS_OFS)) begin
            irq_status_next = irq_status_reg & ~prdata_o[LPM_EV_WIDTH-1:0];
        end
        irq_status_next = irq_status_next | (ev_now & ~ev_prev_reg);
    end

    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            bus_irq_o <= 1'b0;
        end else begin
            bus_irq_o <= |(irq_status_next & irq_mask_reg);
        end
    end

    // Read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        map_hit    = 1'b1;
        if (addr_is(paddr_i, LPM_WAKE_CTRL_STATUS_OFS)) begin
            rdata_next[LPM_CTRL_WIDTH-1:0] = ctrl_reg;
        end else if (addr_is(paddr_i, LPM_STRAP_STATUS_OFS)) begin
            rdata_next[LPM_STRAP_MODE_BIT]   = strap_mode;
            rdata_next[LPM_STRAP_CORE_REGULATOR_DISABLE_STRAP_BIT] = strap_core_regulator_disable_strap;
        end else if (addr_is(paddr_i, LPM_IRQ_STATUS_OFS)) begin
            rdata_next[LPM_EV_WIDTH-1:0] = irq_status_reg;
        end else if (addr_is(paddr_i, LPM_IRQ_MASK_OFS)) begin
            rdata_next[LPM_EV_WIDTH-1:0] = irq_mask_reg;
        end else begin
            map_hit = 1'b0;
        end
    end

    // Zero wait states; pready is a flop set from the setup phase so the access phase lasts one cycle
    always_ff @(posedge clock_i or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !map_hit;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rdata_next : 32'h0000_0000;
        end
    end

endmodule // lpm_pin_select

// ===== verification/lpm_far_side.sv
// Far-side model: strap resistors, transmit-error source, external core rail
`timescale 1ns/10ps
module lpm_far_side (
    // Strap resistors, fitted away from their default pulls when set
    input  wire logic mode_low_i,
    input  wire logic core_regulator_disable_strap_high_i,
    // Shared pin, device side and transmit-error source
    input  wire logic pin_o_i,
    input  wire logic pin_oe_i,
    input  wire logic tx_err_src_i,
    input  wire logic core_regulator_en_i,
    output logic      mode_strap_o,
    output logic      core_regulator_disable_strap_strap_o,
    output logic      pin_level_o,
    output logic      ext_supply_on_o
);
    assign mode_strap_o    = !mode_low_i;
    assign core_regulator_disable_strap_strap_o  = core_regulator_disable_strap_high_i;
    // Only one party drives the wire, so no contention is modelled
    assign pin_level_o     = pin_oe_i ? pin_o_i : tx_err_src_i;
    assign ext_supply_on_o = !core_regulator_en_i;
endmodule // lpm_far_side

// ===== verification/lpm_pin_select_assertions.sv
// Port checker for the pin function selector
`timescale 1ns/10ps
module lpm_pin_select_checker (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic sys_rst_n_i,
    input wire logic link_activity_i,
    input wire logic link_speed_i,
    input wire logic irq_req_i,
    input wire logic wake_req_i,
    input wire logic shared_pin_mode_strap_i,
    input wire logic core_regulator_disable_strap_i,
    input wire logic shared_pin_i,
    input wire logic shared_pin_o,
    input wire logic shared_pin_oe_o,
    input wire logic tx_err_d4_o,
    input wire logic rxd_wake_o,
    input wire logic rxd_wake_oe_o,
    input wire logic status_light_a_o,
    input wire logic core_regulator_en_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // Skips the reset synchroniser and first strap capture
    logic [2:0] up_reg;
    logic       live;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) up_reg <= 3'h0;
        else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
    end
    assign live = (up_reg == 3'h7);
    a_shared_irq_low: assert property (live && !shared_pin_o |-> $past(irq_req_i))
        else $error("shared pin low without interrupt request");
    a_wake_out_low: assert property (live |-> rxd_wake_o == !$past(wake_req_i))
        else $error("wake output does not follow wake request");
    a_light_a_src: assert property (live && status_light_a_o |-> $past(link_activity_i) ||
        $past(link_speed_i) || !$past(irq_req_i) || !$past(wake_req_i))
        else $error("light a high with no selectable source high");
    a_poweron_take: assert property (live && $past(up_reg) == 3'h6 |->
        core_regulator_en_o == !core_regulator_disable_strap_i &&
        shared_pin_oe_o == shared_pin_mode_strap_i)
        else $error("straps not taken at power-on");
    a_strap_take: assert property ((live && !sys_rst_n_i && $stable(shared_pin_mode_strap_i)
        && $stable(core_regulator_disable_strap_i)) [*3] |-> ##[0:3]
        (core_regulator_en_o == !core_regulator_disable_strap_i &&
        shared_pin_oe_o == shared_pin_mode_strap_i))
        else $error("straps not taken during system reset");
    a_strap_hold: assert property (live && sys_rst_n_i && $past(sys_rst_n_i) &&
        $past(sys_rst_n_i, 2) && $past(sys_rst_n_i, 3) |->
        $stable(core_regulator_en_o) && $stable(shared_pin_oe_o))
        else $error("latched strap changed outside reset");
    a_txerr_pass: assert property (live && !shared_pin_oe_o && !$past(shared_pin_oe_o) |->
        tx_err_d4_o == $past(shared_pin_i))
        else $error("transmit error input not passed");
    a_txerr_quiet: assert property (live && shared_pin_oe_o && $past(shared_pin_oe_o) |->
        !tx_err_d4_o)
        else $error("transmit error active in interrupt mode");
    c_irq_shared: cover property (live && shared_pin_oe_o && !shared_pin_o);
    c_txerr_mode: cover property (live && !shared_pin_oe_o && tx_err_d4_o);
    c_wake_rxd: cover property (live && rxd_wake_oe_o && !rxd_wake_o);
endmodule // lpm_pin_select_checker
bind lpm_pin_select lpm_pin_select_checker u_chk (.*);

// ===== verification/tb_top.sv
// Self-checking bench for the pin function selector
`timescale 1ns/10ps
module tb_top;
    logic        clock_i = 1'b0;
    logic        arst_n_i, sys_rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q;
    logic        link_activity_i, link_speed_i, irq_req_i, wake_req_i, e, ext_sup;
    logic        shared_pin_mode_strap_i, core_regulator_disable_strap_i, shared_pin_i;
    logic        shared_pin_o, shared_pin_oe_o, tx_err_d4_o, rxd_wake_o, rxd_wake_oe_o;
    logic        status_light_a_o, status_light_b_o, core_regulator_en_o, bus_irq_o;
    logic        mode_lo, core_regulator_disable_strap_hi, err_src;
    logic [3:0]  v;
    logic [1:0]  ir, wr;
    int          fails = 0, comparisons = 0, seed = 32'h1c71372c;
    always #5 clock_i = ~clock_i;
    lpm_pin_select u_dut (.*);
    lpm_far_side u_far (.mode_low_i(mode_lo), .core_regulator_disable_strap_high_i(core_regulator_disable_strap_hi),
        .pin_o_i(shared_pin_o), .pin_oe_i(shared_pin_oe_o), .tx_err_src_i(err_src),
        .core_regulator_en_i(core_regulator_en_o), .mode_strap_o(shared_pin_mode_strap_i),
        .core_regulator_disable_strap_strap_o(core_regulator_disable_strap_i), .pin_level_o(shared_pin_i),
        .ext_supply_on_o(ext_sup));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr_en;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        chk(n < 20, 32'h1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Outputs lag one clock, so the check waits two edges
    task automatic ev(input logic [3:0] x);
        @(posedge clock_i);
        {link_activity_i, link_speed_i, irq_req_i, wake_req_i} <= x;
        repeat (2) @(posedge clock_i);
    endtask
    function automatic logic lit(input logic [1:0] f, input logic [3:0] x);
        case (f)
            2'h0: lit = x[3];
            2'h1: lit = x[2];
            2'h2: lit = !x[1];
            default: lit = !x[0];
        endcase
    endfunction
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {arst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {link_activity_i, link_speed_i, irq_req_i, wake_req_i} = 4'h0;
        {mode_lo, core_regulator_disable_strap_hi, err_src} = 3'h0;
        sys_rst_n_i = 1'b1;
        repeat (2) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        // Every pull pairing; the last pass restores the defaults
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            {core_regulator_disable_strap_hi, mode_lo} <= 2'(i);
            sys_rst_n_i <= 1'b0;
            repeat (4) @(posedge clock_i);
            sys_rst_n_i <= 1'b1;
            repeat (5) @(posedge clock_i);
            {core_regulator_disable_strap_hi, mode_lo} <= ~2'(i);
            err_src <= 1'b1;
            repeat (4) @(posedge clock_i);
            chk(shared_pin_oe_o, !i[0]);
            chk(core_regulator_en_o, !i[1]);
            chk(tx_err_d4_o, i[0]);
            chk(ext_sup, i[1]);
            apb(1'b0, 12'h004, 32'h0);
            chk(q, {30'h0, i[1], !i[0]});
        end
        $display("test straps done");
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, 12'h000, {24'h0, 4'h3, 2'(3 - f), 2'(f)});
            repeat (6) begin
                v = 4'($random(seed));
                ev(v);
                chk(status_light_a_o, lit(2'(f), v));
                chk(status_light_b_o, lit(2'(3 - f), v));
            end
        end
        $display("test lights done");
        for (int j = 0; j < 6; j++) begin
            ir = (j < 3) ? 2'(j) : 2'h3;
            wr = (j < 3) ? 2'h0 : 2'(j - 2);
            apb(1'b1, 12'h000, {24'h0, wr, ir, 4'h0});
            for (int k = 0; k < 2; k++) begin
                ev({2'h0, k[0], k[0]});
                chk(status_light_a_o, (ir == 2'h1 || wr == 2'h1) && !k[0]);
                chk(status_light_b_o, (ir == 2'h2 || wr == 2'h2) && !k[0]);
                chk(shared_pin_o, ir != 2'h0 || !k[0]);
                chk(rxd_wake_o, !k[0]);
                chk(rxd_wake_oe_o, wr == 2'h3);
            end
        end
        $display("test routes done");
        apb(1'b1, 12'h00c, 32'h0);
        ev(4'h0);
        apb(1'b0, 12'h008, 32'h0);
        ev(4'h2);
        chk(bus_irq_o, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, 12'h00c, 32'h1);
        ev(4'h0);
        ev(4'h2);
        chk(bus_irq_o, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(q, 32'h1);
        repeat (2) @(posedge clock_i);
        chk(bus_irq_o, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk(e, 32'h1);
        chk(q, 32'h0);
        $display("test interrupts done");
        final_report;
    end
    initial begin
        #100000;
        fails++;
        final_report;
    end
endmodule // tb_top
